// ==== hdl/wdtps_cfg.svh ====
// Purpose: constants of the watchdog with postscaler
// Assumes: 10 MHz clk_sys, 32-bit APB
// Notes:   register offsets are word indices, byte address is four times
`ifndef WDTPS_CFG_SVH
`define WDTPS_CFG_SVH
`define WDTPS_CLK_NS        100
`define WDTPS_OSC_NS        1000
`define WDTPS_OSC_CYC       (`WDTPS_OSC_NS / `WDTPS_CLK_NS)
`define WDTPS_IDX_CFG       30'h0000_2007
`define WDTPS_IDX_OPT       30'h0000_0081
`define WDTPS_IDX_STAT      30'h0000_0200
`define WDTPS_IDX_IRQ       30'h0000_0201
`define WDTPS_IDX_MASK      30'h0000_0202
`define WDTPS_CFG_RST       8'hff
`define WDTPS_OPT_RST       8'hff
`define WDTPS_CFG_WATCHDOG_ENABLE_CFG_BIT  2
`define WDTPS_OPT_ASSN_BIT  3
`define WDTPS_OPT_RATE_LSB  0
`define WDTPS_IRQ_RESET_BIT 0
`define WDTPS_IRQ_WAKE_BIT  1
`endif

// ==== hdl/wdtps_pkg.sv ====
// Purpose: types of the watchdog with postscaler
// Assumes: nothing
// Notes:   states of the core power mode
`default_nettype none
package wdtps_pkg;
   typedef enum logic [0:0] {
      WDTPS_RUN,
      WDTPS_SLEEP
   } wdtps_mode_t;
   typedef logic [7:0] wdtps_byte_t;
endpackage : wdtps_pkg
`default_nettype wire

// ==== hdl/wdtps_top.sv ====
// Purpose: watchdog timer with shared scaler, APB register access
// Assumes: instruction strobes are one-cycle pulses synchronous to clk_sys
// Notes:   watchdog oscillator modelled as an enable from a divider
//
// The APB slave port was chosen for this implementation.
`default_nettype none
`include "wdtps_cfg.svh"

module wdtps_top (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        clear_watchdog_instr,
   input  wire logic        sleep_instr,
   input  wire logic        t0_inc_in,
   output logic             t0_tick_out,
   output logic             wdt_reset_req,
   output logic             wake_out,
   output logic             timeout_flag,
   output logic             powerdown_flag,
   output logic             osc_drive_en,
   output logic             in_sleep,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // dividing mask: (2^(rate+extra))-1
   function automatic logic [7:0] rate_mask(input logic [2:0] rate,
                                            input logic       extra);
      logic [8:0] one_hot;
      one_hot   = 9'h001 << ({1'b0, rate} + {3'h0, extra});
      rate_mask = one_hot[7:0] - 8'h01;
      if (one_hot[8]) begin
         rate_mask = 8'hff;
      end
   endfunction : rate_mask

   ////////////////////////////////////////////////////////////////////////
   // registers
   wdtps_pkg::wdtps_byte_t    configuration_word_reg;
   wdtps_pkg::wdtps_byte_t    option_control_reg;
   logic [1:0]                irq_status_reg;
   logic [1:0]                irq_mask_reg;
   logic [1:0]                irq_status_next;
   wdtps_pkg::wdtps_mode_t    mode_reg;
   logic [3:0]                osc_div_reg;
   logic [7:0]                watchdog_counter_reg;
   logic [7:0]                scaler_reg;
   logic                      timeout_flag_reg;
   logic                      powerdown_flag_reg;
   logic                      reset_req_reg;
   logic                      wake_reg;
   logic [31:0]               prdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire        acc_phase  = psel & penable;
   wire [29:0] word_idx   = paddr[31:2];
   wire        hit_cfg    = (word_idx == `WDTPS_IDX_CFG);
   wire        hit_opt    = (word_idx == `WDTPS_IDX_OPT);
   wire        hit_stat   = (word_idx == `WDTPS_IDX_STAT);
   wire        hit_irq    = (word_idx == `WDTPS_IDX_IRQ);
   wire        hit_mask   = (word_idx == `WDTPS_IDX_MASK);
   wire        hit_any    = hit_cfg | hit_opt | hit_stat | hit_irq | hit_mask;
   wire        wr_stb     = acc_phase & pwrite & hit_any;
   wire        wr_cfg     = wr_stb & hit_cfg;
   wire        wr_opt     = wr_stb & hit_opt;
   wire        wr_irq     = wr_stb & hit_irq;
   wire        wr_mask    = wr_stb & hit_mask;

   wire        wdt_enable = configuration_word_reg[`WDTPS_CFG_WATCHDOG_ENABLE_CFG_BIT];
   wire        scaler_assign = option_control_reg[`WDTPS_OPT_ASSN_BIT];
   wire [2:0]  scale_rate = option_control_reg[`WDTPS_OPT_RATE_LSB +: 3];
   wire        sleeping   = (mode_reg == wdtps_pkg::WDTPS_SLEEP);

   // oscillator tick runs regardless of core mode
   wire        osc_tick   = (osc_div_reg == 4'(`WDTPS_OSC_CYC - 1));
   wire        wdt_clear  = clear_watchdog_instr | sleep_instr;
   wire        cnt_ovf    = wdt_enable & osc_tick & (watchdog_counter_reg == 8'hff);
   wire [7:0]  wdt_mask   = scaler_assign ? rate_mask(scale_rate, 1'b0) : 8'h00;
   wire [7:0]  t0_mask    = rate_mask(scale_rate, 1'b1);
   wire        scaler_end = ((scaler_reg & wdt_mask) == wdt_mask);
   wire        timeout    = cnt_ovf & scaler_end & ~wdt_clear;
   wire        t0_scaled  = ~scaler_assign & t0_inc_in &
                            ((scaler_reg & t0_mask) == t0_mask);

   ////////////////////////////////////////////////////////////////////////
   // watchdog oscillator divider
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         osc_div_reg <= 4'h0;
      end else if (osc_tick) begin
         osc_div_reg <= 4'h0;
      end else begin
         osc_div_reg <= osc_div_reg + 4'h1;
      end
   end

   // watchdog counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         watchdog_counter_reg <= 8'h00;
      end else if (wdt_clear || !wdt_enable) begin
         watchdog_counter_reg <= 8'h00;
      end else if (osc_tick) begin
         watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
      end
   end

   // shared scaler: postscaler for the watchdog, prescaler for Timer0
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         scaler_reg <= 8'h00;
      end else if (scaler_assign && wdt_clear) begin
         scaler_reg <= 8'h00;
      end else if (scaler_assign && cnt_ovf) begin
         scaler_reg <= scaler_end ? 8'h00 : scaler_reg + 8'h01;
      end else if (!scaler_assign && t0_inc_in) begin
         scaler_reg <= scaler_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power mode and status flags
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= wdtps_pkg::WDTPS_RUN;
      end else if (timeout && sleeping) begin
         mode_reg <= wdtps_pkg::WDTPS_RUN;
      end else if (sleep_instr) begin
         mode_reg <= wdtps_pkg::WDTPS_SLEEP;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timeout_flag_reg   <= 1'b1;
         powerdown_flag_reg <= 1'b1;
      end else if (timeout) begin
         timeout_flag_reg   <= 1'b0;
         powerdown_flag_reg <= sleeping ? 1'b0 : 1'b1;
      end else if (sleep_instr) begin
         timeout_flag_reg   <= 1'b1;
         powerdown_flag_reg <= 1'b0;
      end else if (clear_watchdog_instr) begin
         timeout_flag_reg   <= 1'b1;
         powerdown_flag_reg <= 1'b1;
      end
   end

   // reset and wake requests are one-cycle pulses
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reset_req_reg <= 1'b0;
         wake_reg      <= 1'b0;
      end else begin
         reset_req_reg <= timeout & ~sleeping;
         wake_reg      <= timeout & sleeping;
      end
   end

   // Timer0 tick held in a flop to keep data outputs registered
   logic t0_tick_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         t0_tick_reg <= 1'b0;
      end else begin
         t0_tick_reg <= t0_scaled;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         configuration_word_reg <= `WDTPS_CFG_RST;
         option_control_reg     <= `WDTPS_OPT_RST;
         irq_mask_reg           <= 2'h0;
      end else begin
         if (wr_cfg) begin
            configuration_word_reg <= pwdata[7:0];
         end
         if (wr_opt) begin
            option_control_reg <= pwdata[7:0];
         end
         if (wr_mask) begin
            irq_mask_reg <= pwdata[1:0];
         end
      end
   end

   // sticky events, write one to clear, a new event beats the clear
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr_irq) begin
         irq_status_next = irq_status_reg & ~pwdata[1:0];
      end
      irq_status_next[`WDTPS_IRQ_RESET_BIT] = irq_status_next[`WDTPS_IRQ_RESET_BIT] | reset_req_reg;
      irq_status_next[`WDTPS_IRQ_WAKE_BIT]  = irq_status_next[`WDTPS_IRQ_WAKE_BIT] | wake_reg;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_status_reg <= 2'h0;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // read data registered in the setup cycle so the access phase is ready
   wire [31:0] rd_mux = hit_cfg  ? {24'h0, configuration_word_reg} :
                        hit_opt  ? {24'h0, option_control_reg} :
                        hit_stat ? {29'h0, sleeping, powerdown_flag_reg,
                                    timeout_flag_reg} :
                        hit_irq  ? {30'h0, irq_status_reg} :
                        hit_mask ? {30'h0, irq_mask_reg} : 32'h0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata         = prdata_reg;
   assign pready         = 1'b1;
   assign pslverr        = acc_phase & ~hit_any;
   assign t0_tick_out    = t0_tick_reg;
   assign wdt_reset_req  = reset_req_reg;
   assign wake_out       = wake_reg;
   assign timeout_flag   = timeout_flag_reg;
   assign powerdown_flag = powerdown_flag_reg;
   assign osc_drive_en   = ~sleeping;
   assign in_sleep       = sleeping;
   assign irq            = |(irq_status_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_tick_at_top;
      wdt_enable && osc_tick && watchdog_counter_reg == 8'hff;
   endsequence

   sequence s_sleep_in;
      sleep_instr && !timeout;
   endsequence

   osc_period_a: assert property (
      osc_tick |=> !osc_tick [*8] ##1 !osc_tick ##1 osc_tick)
      else $error("watchdog oscillator tick period wrong");

   reset_pulse_a: assert property (
      timeout && !sleeping |=> wdt_reset_req && !wake_out ##1 !wdt_reset_req)
      else $error("normal time-out did not pulse reset");

   sleep_wake_a: assert property (
      timeout && sleeping |=> wake_out && !wdt_reset_req && !in_sleep)
      else $error("sleep time-out did not wake");

   to_clear_a: assert property (
      timeout |=> !timeout_flag)
      else $error("time-out flag not cleared");

   wdt_off_a: assert property (
      !wdt_enable |=> watchdog_counter_reg == 8'h00 && !wdt_reset_req [*2])
      else $error("disabled watchdog still counts");

   t0_share_a: assert property (
      scaler_assign |=> !t0_tick_out)
      else $error("Timer0 tick while scaler belongs to watchdog");

   clr_zero_a: assert property (
      wdt_clear |=> watchdog_counter_reg == 8'h00 && !wdt_reset_req)
      else $error("clear did not zero watchdog counter");

   keep_assign_a: assert property (
      clear_watchdog_instr && scaler_assign && !wr_opt |=>
         scaler_reg == 8'h00 && $stable(scaler_assign))
      else $error("clear changed assignment or left scaler count");

   sleep_entry_a: assert property (
      s_sleep_in |=> in_sleep && !osc_drive_en && !powerdown_flag && timeout_flag)
      else $error("sleep entry flags wrong");

   one_to_one_a: assert property (
      s_tick_at_top and (scaler_assign && scale_rate == 3'h0 && !wdt_clear) |-> timeout)
      else $error("rate zero did not time out on each overflow");

endmodule : wdtps_top
`default_nettype wire

// ==== dv/wdtps_test.sv ====
// Purpose: self-checking bench of the watchdog with shared scaler
// Assumes: APB slave may add wait states, 10 MHz clk_sys
// Notes:   watchdog rates 0 and 1 only, so every time-out stays near 2560 or 5120 cycles
`default_nettype none
`include "wdtps_cfg.svh"

module wdtps_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A_CFG  = {`WDTPS_IDX_CFG, 2'b00};
   localparam logic [31:0] A_OPT  = {`WDTPS_IDX_OPT, 2'b00};
   localparam logic [31:0] A_STAT = {`WDTPS_IDX_STAT, 2'b00};
   localparam logic [31:0] A_IRQ  = {`WDTPS_IDX_IRQ, 2'b00};
   localparam logic [31:0] A_MASK = {`WDTPS_IDX_MASK, 2'b00};
   localparam int          OVF    = 256 * `WDTPS_OSC_CYC;
   logic        clk_sys, resetn, psel, penable, pwrite, clr_i, slp_i, t0_i;
   logic [31:0] paddr, pwdata, prdata, d;
   logic        pready, pslverr, t0_tick, rst_req, wake, to_f, pd_f, osc_en, slp_f, irq, e;
   int          bad_count, samples_checked, rst_seen, wake_seen, tick_seen, n, b;

   wdtps_top dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clear_watchdog_instr(clr_i), .sleep_instr(slp_i),
      .t0_inc_in(t0_i), .t0_tick_out(t0_tick), .wdt_reset_req(rst_req),
      .wake_out(wake), .timeout_flag(to_f), .powerdown_flag(pd_f),
      .osc_drive_en(osc_en), .in_sleep(slp_f), .irq(irq));

   always #50 clk_sys = ~clk_sys;

   // one-cycle pulses, counted mid-cycle where they are settled
   always @(negedge clk_sys) begin
      rst_seen += (rst_req === 1'b1);
      wake_seen += (wake === 1'b1);
      tick_seen += (t0_tick === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      // answer taken at the edge that samples pready high, only the bench timeout ends a hang
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(d, exp);
   endtask : rd_chk

   task automatic pulse(input int which);
      @(posedge clk_sys);
      case (which)
         0: clr_i <= 1'b1;
         1: slp_i <= 1'b1;
         default: t0_i <= 1'b1;
      endcase
      @(posedge clk_sys);
      clr_i <= 1'b0;
      slp_i <= 1'b0;
      t0_i <= 1'b0;
   endtask : pulse

   // cycles until the next reset request (0) or wake pulse (1)
   task automatic wait_evt(input int which, input int lim);
      int base;
      base = which ? wake_seen : rst_seen;
      n = 0;
      while ((which ? wake_seen : rst_seen) == base && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : wait_evt

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd_chk(A_CFG, 32'h0000_00ff);
      rd_chk(A_OPT, 32'h0000_00ff);
      rd_chk(A_STAT, 32'h0000_0003);
      rd_chk(32'h0000_0ffc, 32'h0);
      chk(e, 1'b1);
      $display("test regs done");
   endtask : t_regs

   task automatic t_timeout;
      apb(1'b1, A_MASK, 32'h0);
      apb(1'b1, A_OPT, 32'h0000_0008);
      pulse(0);
      wait_evt(0, 2 * OVF);
      chk(n >= OVF - 15 && n <= OVF + 10, 1'b1);
      chk(to_f, 1'b0);
      chk(pd_f, 1'b1);
      repeat (3) @(negedge clk_sys);
      rd_chk(A_IRQ, 32'h0000_0001);
      chk(irq, 1'b0);
      apb(1'b1, A_MASK, 32'h0000_0003);
      @(negedge clk_sys);
      chk(irq, 1'b1);
      apb(1'b1, A_IRQ, 32'h0000_0001);
      @(negedge clk_sys);
      chk(irq, 1'b0);
      $display("test timeout done");
   endtask : t_timeout

   task automatic t_rate;
      apb(1'b1, A_OPT, 32'h0000_0009);
      pulse(0);
      wait_evt(0, 3 * OVF);
      chk(n >= 2 * OVF - 15 && n <= 2 * OVF + 10, 1'b1);
      $display("test rate done");
   endtask : t_rate

   // clears spaced past one overflow: a scaler left uncleared would time out
   task automatic t_clear;
      b = rst_seen;
      repeat (3) begin
         pulse(0);
         repeat (OVF + 900) @(posedge clk_sys);
      end
      chk(rst_seen, b);
      chk(to_f, 1'b1);
      rd_chk(A_OPT, 32'h0000_0009);
      $display("test clear done");
   endtask : t_clear

   task automatic t_sleep;
      apb(1'b1, A_OPT, 32'h0000_0008);
      b = rst_seen;
      pulse(1);
      @(negedge clk_sys);
      chk({slp_f, osc_en, pd_f, to_f}, 4'b1001);
      wait_evt(1, 2 * OVF);
      chk(n >= OVF - 15 && n <= OVF + 10, 1'b1);
      chk(rst_seen, b);
      chk({slp_f, osc_en, to_f}, 3'b010);
      rd_chk(A_STAT, 32'h0);
      rd_chk(A_IRQ, 32'h0000_0003);
      chk(irq, 1'b1);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_disable;
      apb(1'b1, A_CFG, 32'h0000_00fb);
      pulse(0);
      b = rst_seen;
      repeat (OVF + 300) @(posedge clk_sys);
      chk(rst_seen, b);
      $display("test disable done");
   endtask : t_disable

   task automatic t_timer0;
      for (int r = 0; r < 3; r++) begin
         apb(1'b1, A_OPT, 32'(r));
         b = tick_seen;
         repeat (8) pulse(2);
         repeat (3) @(posedge clk_sys);
         chk(tick_seen - b, 8 >> (r + 1));
      end
      $display("test timer0 done");
   endtask : t_timer0

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      $display("CHECK FAILED at %0t: bench timeout", $time);
      stop_test();
   end

   initial begin
      {clk_sys, resetn, psel, penable, pwrite, clr_i, slp_i, t0_i} = 8'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_timeout();
      t_rate();
      t_clear();
      t_sleep();
      t_disable();
      t_timer0();
      stop_test();
   end
endmodule : wdtps_test
`default_nettype wire
